// [rtl/pcrc_consts.vh]
// Purpose: Constants for the programmable checksum engine
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Offsets are chosen locally; no offsets are published
`ifndef PCRC_CONSTS_VH
`define PCRC_CONSTS_VH
`define PCRC_OFF_CTRL_LO 12'h000
`define PCRC_OFF_CTRL_HI 12'h004
`define PCRC_OFF_POLY_LO 12'h008
`define PCRC_OFF_POLY_HI 12'h00C
`define PCRC_OFF_DATA 12'h010
`define PCRC_OFF_RESULT 12'h014
`define PCRC_OFF_IRQ_STAT 12'h018
`define PCRC_OFF_IRQ_MASK 12'h01C
`define PCRC_OFF_SEED 12'h020
`define PCRC_BIT_EN 15
`define PCRC_BIT_IDLE 13
`define PCRC_BIT_FULL 7
`define PCRC_BIT_EMPTY 6
`define PCRC_BIT_ISEL 5
`define PCRC_BIT_GO 4
`define PCRC_BIT_ORDER 3
`define PCRC_BIT_VARIANT 2
`define PCRC_CNT_LSB 8
`define PCRC_WID_LSB 8
`define PCRC_CTRL_LO_WMASK 16'hA03C
`define PCRC_CTRL_HI_WMASK 16'h1F1F
`define PCRC_POLY_LO_WMASK 16'hFFFE
`define PCRC_DEPTH_WIDE 5'h08
`define PCRC_DEPTH_NARROW 5'h10
`define PCRC_PLEN_WIDE 5'h07
`endif

// [rtl/pcrc_engine.v]
// Purpose: Programmable checksum engine up to 32 bits with input FIFO, APB slave
// Assumes: Single clock pclk, async active-low presetn, software sole master
// Notes: Overview of operation below; one bit shifted per enabled cycle
// Overview of operation
// RULE1: The enable bit switches the whole engine on when set and holds it idle when clear.
// RULE2: With the idle-stop bit set the engine halts while the device idle input is high.
// RULE3: A 5-bit read-only count gives the FIFO fill, capped at 8 for length >= 7, else 16.
// RULE4: The full flag reads 1 exactly when the FIFO holds its maximum word count.
// RULE5: The empty flag reads 1 exactly when the FIFO is empty and resets to 1.
// RULE6: Interrupt select picks FIFO-empty-while-shifting when set, shift-done when clear.
// RULE7: Writing 1 to start runs the shifter, writing 0 stops it, and hardware clears it.
// RULE8: The order bit feeds each word LSB first when set and MSB first when clear.
// RULE9: The variant bit selects the alternate calculation mode when set, legacy when clear.
// RULE10: The 5-bit width field holds data width minus one, giving 1 to 32 bit words.
// RULE11: The 5-bit length field holds polynomial length minus one, up to 32 bits.
// RULE12: Term enable bits 1 to 31 gate XOR feedback per power; term 0 reads as 0.
// RULE13: Unimplemented bits in control and polynomial registers ignore writes, read 0.
// RULE14: Words written to the data register are shifted bitwise into a readable remainder.
// RULE15: The selected event gives a one-cycle pulse that never blocks FIFO writes.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "pcrc_consts.vh"
module pcrc_engine #(
  parameter DEPTH = 16
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Device state
  input wire device_idle,
  // Interrupts
  output reg irq_pulse,
  output reg irq
);

  reg [15:0] ctrl_lo;
  reg [15:0] ctrl_hi;
  reg [31:0] poly;
  reg [31:0] remainder;
  reg [31:0] fifo_mem [0:DEPTH-1];
  reg [3:0] rd_ptr;
  reg [3:0] wr_ptr;
  reg [4:0] count;
  reg [31:0] cur_word;
  reg [5:0] bits_left;
  reg busy;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg idle_s1;
  reg idle_s2;

  wire [4:0] wid = ctrl_hi[`PCRC_WID_LSB +: 5];
  wire [4:0] plen = ctrl_hi[4:0];
  wire order_lsb = ctrl_lo[`PCRC_BIT_ORDER];
  wire variant = ctrl_lo[`PCRC_BIT_VARIANT];
  wire go = ctrl_lo[`PCRC_BIT_GO];
  wire isel = ctrl_lo[`PCRC_BIT_ISEL];
  // Overlap at 7 resolved toward the smaller depth
  wire [4:0] cap = (plen >= `PCRC_PLEN_WIDE) ? `PCRC_DEPTH_WIDE : `PCRC_DEPTH_NARROW; // RULE3
  wire full = (count == cap); // RULE4
  wire empty = (count == 5'h00); // RULE5
  // Engine runs only when enabled and not stopped by idle
  wire run = ctrl_lo[`PCRC_BIT_EN] & ~(ctrl_lo[`PCRC_BIT_IDLE] & idle_s2); // RULE1 RULE2
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire push = wr & (paddr == `PCRC_OFF_DATA) & ~full & ctrl_lo[`PCRC_BIT_EN];
  wire load = run & go & ~busy & ~empty;
  wire shift = run & busy;
  wire last_bit = shift & (bits_left == 6'h01);
  wire done_evt = last_bit & empty & ~load;
  wire empty_evt = load & (count == 5'h01) & busy == 1'b0;
  wire [31:0] pmask = mask_of(plen);

  // Mask of polynomial width
  function [31:0] mask_of;
    input [4:0] n;
    begin
      mask_of = 32'hFFFFFFFF >> (5'h1F - n); // RULE11
    end
  endfunction

  // Next data bit picked from the word by order and position
  function in_bit;
    input [31:0] w;
    input [5:0] left;
    input [4:0] width;
    input lsb;
    reg [5:0] idx;
    begin
      idx = lsb ? ({1'b0, width} - (left - 6'h01)) : (left - 6'h01);
      in_bit = w[idx[4:0]]; // RULE8
    end
  endfunction

  wire dbit = in_bit(cur_word, bits_left, wid, order_lsb);
  wire topb = remainder[plen];
  // Legacy: data enters at the bottom; alternate: data mixes at the top
  wire fb = variant ? (topb ^ dbit) : topb; // RULE9
  wire [31:0] shifted = {remainder[30:0], variant ? 1'b0 : dbit};
  // Term 0 has no storage but always feeds back, in both modes
  wire [31:0] next_rem = (shifted ^ (fb ? {poly[31:1], 1'b1} : 32'h0)) & pmask; // RULE12

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
    end else begin
      idle_s1 <= device_idle;
      idle_s2 <= idle_s1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_lo <= 16'h0000;
      ctrl_hi <= 16'h0000;
      poly <= 32'h00000000;
      irq_mask <= 2'h0;
    end else begin
      if (wr && paddr == `PCRC_OFF_CTRL_LO) begin
        ctrl_lo <= pwdata[15:0] & `PCRC_CTRL_LO_WMASK; // RULE13 RULE7
      end else if (busy == 1'b0 && empty && go && run) begin
        ctrl_lo[`PCRC_BIT_GO] <= 1'b0; // RULE7
      end
      if (wr && paddr == `PCRC_OFF_CTRL_HI) begin
        ctrl_hi <= pwdata[15:0] & `PCRC_CTRL_HI_WMASK; // RULE10 RULE11 RULE13
      end
      if (wr && paddr == `PCRC_OFF_POLY_LO) begin
        poly[15:0] <= pwdata[15:0] & `PCRC_POLY_LO_WMASK; // RULE12 RULE13
      end
      if (wr && paddr == `PCRC_OFF_POLY_HI) begin
        poly[31:16] <= pwdata[15:0]; // RULE12
      end
      if (wr && paddr == `PCRC_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // FIFO and shifter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count <= 5'h00;
      busy <= 1'b0;
      bits_left <= 6'h00;
      cur_word <= 32'h00000000;
      remainder <= 32'h00000000;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr] <= pwdata;
        wr_ptr <= wr_ptr + 4'h1;
      end
      case ({push, load})
        2'b10: count <= count + 5'h01;
        2'b01: count <= count - 5'h01;
        default: count <= count;
      endcase // RULE3
      if (wr && paddr == `PCRC_OFF_SEED) begin
        remainder <= pwdata;
      end else if (shift) begin
        remainder <= next_rem; // RULE14
      end
      if (load) begin
        cur_word <= fifo_mem[rd_ptr];
        rd_ptr <= rd_ptr + 4'h1;
        bits_left <= {1'b0, wid} + 6'h01;
        busy <= 1'b1;
      end else if (shift) begin
        bits_left <= bits_left - 6'h01;
        if (last_bit) begin
          busy <= 1'b0;
        end
      end
      if (!go) begin
        busy <= 1'b0; // RULE7
      end
    end
  end

  // Interrupt events: sticky status, read clears, set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
      irq_pulse <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_pulse <= isel ? empty_evt : done_evt; // RULE6 RULE15
      // Clear only what the read reported, so an event after the setup edge is kept
      irq_stat <= ((rd && paddr == `PCRC_OFF_IRQ_STAT) ? (irq_stat & ~prdata[1:0]) : irq_stat)
                  | {empty_evt, done_evt};
      irq <= |(irq_stat & irq_mask);
    end
  end

  // APB read, zero wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `PCRC_OFF_CTRL_LO: prdata <= {16'h0000, ctrl_lo[15:13], count, full, empty,
                                        ctrl_lo[5:0]}; // RULE4 RULE5
          `PCRC_OFF_CTRL_HI: prdata <= {16'h0000, ctrl_hi};
          `PCRC_OFF_POLY_LO: prdata <= {16'h0000, poly[15:0]};
          `PCRC_OFF_POLY_HI: prdata <= {16'h0000, poly[31:16]};
          `PCRC_OFF_RESULT: prdata <= remainder;
          `PCRC_OFF_IRQ_STAT: prdata <= {30'h0, irq_stat};
          `PCRC_OFF_IRQ_MASK: prdata <= {30'h0, irq_mask};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [sim/pcrc_engine_assertions.sv]
// Purpose: Port checks for pcrc_engine
// Assumes: APB reads judged at the access edge
// Notes: Register reads only seen when software reads
`timescale 1ns/100ps
`include "pcrc_consts.vh"
module pcrc_engine_assertions (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Device and interrupts
  input wire device_idle,
  input wire irq_pulse,
  input wire irq
);
  wire rd = pready && !pwrite;
  wire rd_lo = rd && paddr == `PCRC_OFF_CTRL_LO;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  setup_answered_a: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  no_slave_error_a: assert property (!pslverr)
    else $error("pslverr raised");
  ctrl_lo_unused_a: assert property (rd_lo |-> prdata[14] == 0 && prdata[1:0] == 0)
    else $error("ctrl_lo unused bit set");
  empty_vs_count_a: assert property (rd_lo |-> prdata[6] == (prdata[12:8] == 0))
    else $error("empty flag disagrees");
  full_at_cap_a: assert property (rd_lo && prdata[7] |-> prdata[12:8] inside {8, 16})
    else $error("full flag off cap");
  count_ceiling_a: assert property (rd_lo |-> prdata[12:8] <= 16)
    else $error("count above ceiling");
  poly_term_zero_a: assert property (rd && paddr == `PCRC_OFF_POLY_LO |-> !prdata[0])
    else $error("term 0 reads 1");
  ctrl_hi_unused_a: assert property (rd && paddr == `PCRC_OFF_CTRL_HI |->
    (prdata & ~32'h00001F1F) == 0) else $error("ctrl_hi unused bit set");
  irq_single_a: assert property (irq_pulse |=> !irq_pulse)
    else $error("irq pulse too long");
endmodule
bind pcrc_engine pcrc_engine_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .device_idle(device_idle), .irq_pulse(irq_pulse),
  .irq(irq));

// [sim/tb_programmable_crc_generator.sv]
// Purpose: Self-checking bench for pcrc_engine
// Assumes: One APB master, words of 8 or 32 bits, both calculation modes
// Notes: Idle halt, FIFO cap boundary and a reset after activity are covered
`timescale 1ns/100ps
`include "pcrc_consts.vh"
module tb_programmable_crc_generator;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, device_idle = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd, rem, poly, base;
  wire [31:0] prdata;
  wire pready, pslverr, irq_pulse, irq;
  integer errors = 0, n_checks = 0, seed = 73291, i, j, cap, plen, wid, pulses = 0;
  reg [31:0] q[$];
  always #5 pclk = ~pclk;
  // Pulses counted per test against the selected cause
  always @(posedge pclk) if (irq_pulse === 1'b1) pulses = pulses + 1;
  pcrc_engine #(.DEPTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_idle(device_idle), .irq_pulse(irq_pulse),
    .irq(irq));
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // Reference remainder, bit-serial, term 0 always fed back
  function [31:0] crc(input [31:0] r, input [31:0] d, input [4:0] pm1, input lsb,
    input [31:0] p, input alt, input [5:0] w);
    integer b;
    reg fb, db;
    begin
      for (b = 0; b < w; b = b + 1) begin
        db = d[lsb ? b : w - 1 - b];
        fb = r[pm1] ^ (alt & db);
        r = ((r << 1) | (alt ? 1'b0 : db)) ^ (fb ? p | 32'h00000001 : 32'h00000000);
      end
      crc = r & (32'hFFFFFFFF >> (31 - pm1));
    end
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #400000;
    errors = errors + 1;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `PCRC_OFF_CTRL_LO, 0);
    chk(rd, 32'h00000040, "ctrl_lo");
    apb(1, `PCRC_OFF_CTRL_HI, 32'hFFFFFFFF);
    apb(0, `PCRC_OFF_CTRL_HI, 0);
    chk(rd, 32'h00001F1F, "ctrl_hi");
    apb(0, 12'h024, 0);
    chk(rd, 32'h00000000, "unmapped");
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      plen = i == 0 ? 31 : i == 1 ? 7 : i == 2 ? 3 : 6;
      wid = i == 3 ? 7 : 31;
      cap = plen >= 7 ? 8 : 16;
      base = (i != 2 ? 32'h00002000 : 32'h0) | (i < 2 ? 32'h00000004 : 32'h0)
             | (i[0] ? 32'h00000028 : 32'h0);
      poly = $random(seed) & 32'hFFFFFFFE;
      apb(1, `PCRC_OFF_CTRL_HI, (wid << 8) | plen);
      apb(1, `PCRC_OFF_POLY_LO, poly | 32'h00000001);
      apb(1, `PCRC_OFF_POLY_HI, {16'hFFFF, poly[31:16]});
      apb(0, `PCRC_OFF_POLY_LO, 0);
      chk(rd, poly & 32'h0000FFFE, "poly_lo");
      apb(0, `PCRC_OFF_POLY_HI, 0);
      chk(rd, poly >> 16, "poly_hi");
      // Ones on every read-only and unused bit must not stick
      apb(1, `PCRC_OFF_CTRL_LO, base | 32'hFFFFDFC3);
      apb(1, `PCRC_OFF_IRQ_MASK, 32'h00000001 << i[0]);
      apb(1, `PCRC_OFF_SEED, 0);
      q.delete();
      pulses = 0;
      // One word past the cap is dropped
      for (j = 0; j <= cap; j = j + 1) begin
        rem = $random(seed);
        if (q.size() < cap)
          q.push_back(rem);
        apb(1, `PCRC_OFF_DATA, rem);
      end
      apb(0, `PCRC_OFF_CTRL_LO, 0);
      chk(rd, base | 32'h00008080 | (cap << 8), "ctrl_lo");
      // Idle with the stop bit halts; idle without it keeps shifting
      device_idle <= i == 0 || i == 2;
      apb(1, `PCRC_OFF_CTRL_LO, base | 32'h00008010);
      repeat (40) @(posedge pclk);
      apb(0, `PCRC_OFF_CTRL_LO, 0);
      if (i == 0)
        chk(rd[12:8], cap, "halted");
      else
        chk(rd[12:8] < cap, 1, "running");
      device_idle <= 1'b0;
      rem = 0;
      foreach (q[j]) rem = crc(rem, q[j], plen, i[0], poly, i < 2, wid + 1);
      do apb(0, `PCRC_OFF_CTRL_LO, 0); while (rd[4] !== 1'b0);
      apb(0, `PCRC_OFF_RESULT, 0);
      chk(rd, rem, "result");
      chk(pulses, 1, "pulses");
      chk(irq, 1, "irq");
      apb(0, `PCRC_OFF_IRQ_STAT, 0);
      chk(rd, 32'h00000003, "status");
      @(posedge pclk);
      chk(irq, 0, "irq_clr");
      $display("test %0d done", i);
    end
    // Reset again after activity: control cleared, FIFO empty
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `PCRC_OFF_CTRL_LO, 0);
    chk(rd, 32'h00000040, "rst_lo");
    $display("test reset again done");
    tally_and_finish;
  end
endmodule
